// ---- scbc_checker.sv ----
// Checker for the soft command and boost configuration bank
`timescale 1ns/1ns
module scbc_checker import scbc_pkg::*; #(
    parameter int TIMEOUT_CYCLES = 20000
) (
    // Clock, reset and controls
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    input wire logic wdog_enable_in,
    input wire logic sync_n_in,
    // Watched outputs
    input scbc_boost_type boost_cfg_out,
    input wire logic user_toggle_out,
    input wire logic soft_reset_out,
    input wire logic alert_out,
    input wire logic [CHANNELS*SLEW_W-1:0] slew_cfg_out,
    input wire logic [CHANNELS-1:0] slew_en_out
);
    // Boost defaults after any reset
    localparam scbc_boost_type RST_B = '{RST_COMP, RST_PHASE, RST_FREQ,
        RST_LIMIT};
    // Cycles of enabled watchdog; service does not clear it, so a bound
    int en_cnt;
    default clocking cb @(posedge mclk_in); endclocking
    // Frozen clock enable would break timing, so it disables too
    default disable iff (srst_in || !clk_en_in);
    // Enable run counter, saturating
    always_ff @(posedge mclk_in) begin
        if (srst_in || soft_reset_out || !wdog_enable_in) begin
            en_cnt <= 0;
        end else if (en_cnt < TIMEOUT_CYCLES) begin
            en_cnt <= en_cnt + 1;
        end
    end
    AST_RST_BOOST: assert property ($fell(srst_in) |-> boost_cfg_out == RST_B)
        else $error("boost config not at default after reset");
    AST_RST_ZERO: assert property ($fell(srst_in) |-> !user_toggle_out
        && !alert_out && slew_cfg_out == '0)
        else $error("status or slew not cleared by reset");
    AST_SOFT_CLEAR: assert property (soft_reset_out |=>
        boost_cfg_out == RST_B && !user_toggle_out)
        else $error("soft reset did not clear state");
    AST_PULSE_ONE: assert property (soft_reset_out |=> !soft_reset_out)
        else $error("soft reset pulse too long");
    AST_ALERT_OFF: assert property (!wdog_enable_in [*3] |-> !alert_out)
        else $error("alert high with watchdog disabled");
    AST_ALERT_LATE: assert property ($rose(alert_out) |->
        en_cnt >= TIMEOUT_CYCLES - 2)
        else $error("alert raised before timeout");
    AST_QUIET: assert property (sync_n_in [*8] |=> $past(soft_reset_out)
        || $stable({boost_cfg_out, user_toggle_out, slew_cfg_out}))
        else $error("state changed with no frame");
    AST_EN_MATCH: assert property (slew_en_out == {slew_cfg_out[51],
        slew_cfg_out[38], slew_cfg_out[25], slew_cfg_out[12]})
        else $error("slew enable differs from slew word");
    // Main scenarios
    cover property (soft_reset_out);
    cover property ($rose(alert_out));
    cover property (!$stable(slew_en_out));
endmodule : scbc_checker
bind scbc_regs scbc_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    scbc_checker_inst (.mclk_in, .srst_in, .clk_en_in, .wdog_enable_in,
    .sync_n_in, .boost_cfg_out, .user_toggle_out, .soft_reset_out,
    .alert_out, .slew_cfg_out, .slew_en_out);

// ---- scbc_host.sv ----
// Host model driving the three-wire serial port
`timescale 1ns/1ns
module scbc_host (
    // Bench clock
    input wire logic mclk_in,
    // Serial pins towards the device
    output logic sclk_out,
    output logic sync_n_out,
    output logic data_out
);
    // Idle: no frame, clock parked high
    initial begin
        sync_n_out = 1'b1;
        sclk_out = 1'b1;
        data_out = 1'b0;
    end
    // whole word, MSB first, 4 mclk per clock phase
    task automatic send(input logic [15:0] w);
        @(posedge mclk_in) sync_n_out <= 1'b0;
        repeat (4) @(posedge mclk_in);
        for (int i = 15; i >= 0; i--) begin
            sclk_out <= 1'b0;
            data_out <= w[i];
            repeat (4) @(posedge mclk_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge mclk_in);
        end
        // Released line shows the inverse, not a stale bit
        sync_n_out <= 1'b1;
        data_out <= ~w[0];
        repeat (12) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask : send
endmodule : scbc_host

// ---- scbc_pkg.sv ----
// Package for the soft command and boost configuration register bank
package scbc_pkg;
    // Word layout
    localparam int WORD_W = 16;
    localparam int TAG_HI = 15;
    localparam int TAG_LO = 13;
    localparam int TOGGLE_BIT = 12;
    localparam int CODE_HI = 11;
    localparam int CODE_LO = 0;
    localparam int COMP_BIT = 6;
    localparam int PHASE_HI = 5;
    localparam int PHASE_LO = 4;
    localparam int FREQ_HI = 3;
    localparam int FREQ_LO = 2;
    localparam int LIMIT_HI = 1;
    localparam int LIMIT_LO = 0;
    localparam int STATUS_TOGGLE_BIT = 11;
    localparam int SLEW_W = 13;
    localparam int CHANNELS = 4;
    // Word selector tags
    localparam logic [2:0] TAG_SOFT_CMD = 3'h4;
    localparam logic [2:0] TAG_BOOST_CFG = 3'h3;
    localparam logic [2:0] TAG_SLEW = 3'h0;
    // Command codes
    localparam logic [11:0] CODE_RESET = 12'h555;
    localparam logic [11:0] CODE_SERVICE = 12'h195;
    // Reset values of the boost fields
    localparam logic RST_COMP = 1'h0;
    localparam logic [1:0] RST_PHASE = 2'h0;
    localparam logic [1:0] RST_FREQ = 2'h1;
    localparam logic [1:0] RST_LIMIT = 2'h0;
    // Slew enable bit within the slew word
    localparam int SLEW_EN_BIT = 12;
    // Boost configuration carrier
    typedef struct packed {
        logic comp_resistor_select;
        logic [1:0] converter_phase_select;
        logic [1:0] switching_freq_select;
        logic [1:0] boost_limit_select;
    } scbc_boost_type;
    // Shift state machine
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b11
    } scbc_state_type;
endpackage : scbc_pkg

// ---- scbc_regs.sv ----
// Register decode and storage for soft command and boost configuration
//
// Behaviour
// - Tag 100 decodes as software command word
// - Command bit 12 copied into status bit 11
// - Code 0x555 performs self reset of all but the pin synchronisers
// - Missed service while enabled raises alert
// - Tag 011 is boost config, 12..7 ignored
// - Bit 6 selects compensation resistor bypass
// - Bits 5..4 select inter-channel clock phase
// - Bits 3..2 select switching frequency divider
// - Bits 1..0 select maximum boost voltage
// - Slew settings kept per channel separately
`timescale 1ns/1ns
module scbc_regs import scbc_pkg::*; #(
    parameter int TIMEOUT_CYCLES = 20000
) (
    // Clock, reset, enable
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    // Watchdog control from the main control word
    input wire logic wdog_enable_in,
    // Serial pins
    input wire logic sclk_in,
    input wire logic sync_n_in,
    input wire logic serial_in_in,
    // Boost configuration outputs
    output scbc_boost_type boost_cfg_out,
    // Status and alert
    output logic user_toggle_out,
    output logic soft_reset_out,
    output logic alert_out,
    // Per-channel slew words
    output logic [CHANNELS*SLEW_W-1:0] slew_cfg_out,
    output logic [CHANNELS-1:0] slew_en_out
);
    // Two-stage synchronisers for the pins
    logic [1:0] sclk_s;
    logic [1:0] sync_s;
    logic [1:0] sdi_s;
    logic sclk_d;               // Previous synced clock for edges
    logic [WORD_W-1:0] shreg;   // Incoming word
    logic [4:0] bit_cnt;        // Bits captured this frame
    scbc_state_type state;
    logic word_done;            // One-cycle pulse at frame end
    logic [WORD_W-1:0] word;    // Latched complete word
    logic [31:0] wd_cnt;        // Watchdog count-up timer
    logic [1:0] chan_sel;       // Channel for slew words
    logic sclk_rise;
    logic soft_hit;

    // Synchronisers; the first stage feeds only the second
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            // Clock chain parked high, so release makes no false edge
            sclk_s <= '1;
            sync_s <= 2'h3;
            sdi_s <= '0;
            sclk_d <= 1'b1;
        end else if (clk_en_in) begin
            sclk_s <= {sclk_s[0], sclk_in};
            sync_s <= {sync_s[0], sync_n_in};
            sdi_s <= {sdi_s[0], serial_in_in};
            sclk_d <= sclk_s[1];
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_d;

    // Word decode helper, used by the command, boost and slew decodes
    function automatic logic is_tag(input logic [WORD_W-1:0] w,
                                    input logic [2:0] t);
        is_tag = (w[TAG_HI:TAG_LO] == t);
    endfunction : is_tag

    // Frame shift state machine; frame ends when select rises
    always_ff @(posedge mclk_in) begin
        if (srst_in || soft_reset_out) begin
            state <= ST_IDLE;
            shreg <= '0;
            bit_cnt <= '0;
            word_done <= 1'b0;
            word <= '0;
        end else if (clk_en_in) begin
            word_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    bit_cnt <= '0;
                    if (!sync_s[1]) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (sync_s[1]) begin
                        state <= ST_DONE;
                    end else if (sclk_rise) begin
                        // Keeps the last sixteen bits of the frame
                        shreg <= {shreg[WORD_W-2:0], sdi_s[1]};
                        if (bit_cnt != 5'h1f) begin
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                    end
                end
                ST_DONE: begin
                    // Short frames are discarded
                    if (bit_cnt >= 5'(WORD_W)) begin
                        word <= shreg;
                        word_done <= 1'b1;
                    end
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign soft_hit = word_done & is_tag(word, TAG_SOFT_CMD);

    // Toggle bit mirror into the status word
    always_ff @(posedge mclk_in) begin
        if (srst_in || soft_reset_out) begin
            user_toggle_out <= 1'b0;
        end else if (clk_en_in) begin
            // every command write copies the toggle
            // non-matching codes touch only this bit
            if (soft_hit) begin
                user_toggle_out <= word[TOGGLE_BIT];
            end
        end
    end

    // Software reset pulse; one cycle, then clears all state except the pin synchronisers
    always_ff @(posedge mclk_in) begin
        if (srst_in || soft_reset_out) begin
            soft_reset_out <= 1'b0;
        end else if (clk_en_in) begin
            soft_reset_out <= soft_hit &&
                (word[CODE_HI:CODE_LO] == CODE_RESET);
        end
    end

    // Watchdog count-up timer, cleared by the service code
    always_ff @(posedge mclk_in) begin
        if (srst_in || soft_reset_out) begin
            wd_cnt <= '0;
            alert_out <= 1'b0;
        end else if (clk_en_in) begin
            if (!wdog_enable_in) begin
                wd_cnt <= '0;
                alert_out <= 1'b0;
            // host service code restarts the timer
            end else if (soft_hit &&
                         word[CODE_HI:CODE_LO] == CODE_SERVICE) begin
                wd_cnt <= '0;
                alert_out <= 1'b0;
            end else if (wd_cnt >= 32'(TIMEOUT_CYCLES - 1)) begin
                alert_out <= 1'b1;
            end else begin
                wd_cnt <= wd_cnt + 32'h1;
            end
        end
    end

    // Boost configuration storage
    always_ff @(posedge mclk_in) begin
        if (srst_in || soft_reset_out) begin
            boost_cfg_out.comp_resistor_select <= RST_COMP;
            boost_cfg_out.converter_phase_select <= RST_PHASE;
            boost_cfg_out.switching_freq_select <= RST_FREQ;
            boost_cfg_out.boost_limit_select <= RST_LIMIT;
        end else if (clk_en_in) begin
            if (word_done && is_tag(word, TAG_BOOST_CFG)) begin
                boost_cfg_out.comp_resistor_select <= word[COMP_BIT];
                boost_cfg_out.converter_phase_select <=
                    word[PHASE_HI:PHASE_LO];
                boost_cfg_out.switching_freq_select <=
                    word[FREQ_HI:FREQ_LO];
                boost_cfg_out.boost_limit_select <=
                    word[LIMIT_HI:LIMIT_LO];
            end
        end
    end

    // Channel pointer for slew words, set as a plain input is absent
    always_ff @(posedge mclk_in) begin
        if (srst_in || soft_reset_out) begin
            chan_sel <= '0;
        end else if (clk_en_in) begin
            // Slew words fill channels in turn, A first
            if (word_done && is_tag(word, TAG_SLEW)) begin
                chan_sel <= chan_sel + 2'h1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_slew
            always_ff @(posedge mclk_in) begin
                if (srst_in || soft_reset_out) begin
                    slew_cfg_out[g*SLEW_W +: SLEW_W] <= '0;
                    slew_en_out[g] <= 1'b0;
                end else if (clk_en_in) begin
                    if (word_done && is_tag(word, TAG_SLEW) &&
                        chan_sel == 2'(g)) begin
                        slew_cfg_out[g*SLEW_W +: SLEW_W] <=
                            word[SLEW_W-1:0];
                        slew_en_out[g] <= word[SLEW_EN_BIT];
                    end
                end
            end
        end
    endgenerate
endmodule : scbc_regs

// ---- tb.sv ----
// Self-checking bench for the soft command and boost configuration bank
`timescale 1ns/1ns
module tb import scbc_pkg::*;;
    localparam int TO = 600;
    // Stimulus and observed signals
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic wdog_enable_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic sclk, sync_n, sdata, user_toggle_out, soft_reset_out, alert_out;
    scbc_boost_type boost_cfg_out;
    logic [CHANNELS*SLEW_W-1:0] slew_cfg_out, exp_s;
    logic [CHANNELS-1:0] slew_en_out, exp_en;
    logic [15:0] w;
    int bad_count = 0;
    int checks = 0;
    int pulses = 0;
    scbc_host host_inst (.mclk_in(mclk_in), .sclk_out(sclk),
        .sync_n_out(sync_n), .data_out(sdata));
    // Clock enable driven, so a frozen frame can be tried
    scbc_regs #(.TIMEOUT_CYCLES(TO)) scbc_regs_inst (.mclk_in(mclk_in),
        .srst_in(srst_in), .clk_en_in(clk_en_in),
        .wdog_enable_in(wdog_enable_in),
        .sclk_in(sclk), .sync_n_in(sync_n), .serial_in_in(sdata),
        .boost_cfg_out(boost_cfg_out), .user_toggle_out(user_toggle_out),
        .soft_reset_out(soft_reset_out), .alert_out(alert_out),
        .slew_cfg_out(slew_cfg_out), .slew_en_out(slew_en_out));
    // Expected boost fields from a written word
    function automatic logic [51:0] exp_boost(input logic [15:0] v);
        return 52'(v[6:0]);
    endfunction : exp_boost
    task automatic chk_word(input string n, input logic [51:0] e,
        input logic [51:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_word(n, 52'(e), 52'(g));
    endtask : chk_bit
    task automatic finish_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    // Soft reset pulse counter
    always @(posedge mclk_in) if (soft_reset_out === 1'b1) pulses <= pulses + 1;
    // Watchdog: about twice the expected run
    initial begin
        #(10000 * 50);
        bad_count++;
        finish_test();
    end
    initial begin
        void'($urandom(1299));
        repeat (3) @(posedge mclk_in);
        srst_in <= 1'b0;
        // Boost words: every code of every field, then random
        for (int i = 0; i < 6; i++) begin
            w = {3'h3, 13'($urandom)};
            if (i < 4) w[6:0] = {1'(i), 2'(i), 2'(i), 2'(i)};
            host_inst.send(w);
            chk_word("boost", exp_boost(w), 52'(boost_cfg_out));
        end
        // Frozen clock enable: a whole frame must be missed
        @(posedge mclk_in) clk_en_in <= 1'b0;
        host_inst.send({TAG_BOOST_CFG, ~w[12:0]});
        @(posedge mclk_in) clk_en_in <= 1'b1;
        repeat (8) @(posedge mclk_in);
        @(negedge mclk_in);
        chk_word("boost frozen", exp_boost(w), 52'(boost_cfg_out));
        // Plain code sets toggle only, then cleared, then foreign tag
        host_inst.send(16'h9abc);
        chk_bit("toggle", 1'b1, user_toggle_out);
        chk_word("boost kept", exp_boost(w), 52'(boost_cfg_out));
        host_inst.send(16'h8123);
        chk_bit("toggle", 1'b0, user_toggle_out);
        host_inst.send(16'hb000);
        chk_bit("toggle", 1'b0, user_toggle_out);
        // Reset code with toggle bit set
        host_inst.send(16'h9555);
        chk_word("pulses", 52'h1, 52'(pulses));
        chk_bit("toggle", 1'b0, user_toggle_out);
        chk_word("boost", 52'h4, 52'(boost_cfg_out));
        // Slew words fill the channels in turn
        for (int c = 0; c < CHANNELS; c++) begin
            w = {3'h0, 13'($urandom)};
            exp_s[c*SLEW_W +: SLEW_W] = w[12:0];
            exp_en[c] = w[SLEW_EN_BIT];
            host_inst.send(w);
        end
        chk_word("slew", exp_s, slew_cfg_out);
        chk_word("slew en", 52'(exp_en), 52'(slew_en_out));
        // Watchdog kept alive, then starved
        @(posedge mclk_in) wdog_enable_in <= 1'b1;
        repeat (3) host_inst.send({4'h8, CODE_SERVICE});
        chk_bit("alert", 1'b0, alert_out);
        repeat (TO + 100) @(posedge mclk_in);
        @(negedge mclk_in);
        chk_bit("alert", 1'b1, alert_out);
        host_inst.send({4'h8, CODE_SERVICE});
        chk_bit("alert", 1'b0, alert_out);
        repeat (TO + 100) @(posedge mclk_in);
        wdog_enable_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
        chk_bit("alert", 1'b0, alert_out);
        // Mid-run reset returns the boost and slew registers to their defaults
        @(posedge mclk_in) srst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(negedge mclk_in);
        chk_word("boost rst", 52'({RST_COMP, RST_PHASE, RST_FREQ,
            RST_LIMIT}), 52'(boost_cfg_out));
        chk_word("slew rst", 52'h0, slew_cfg_out);
        finish_test();
    end
endmodule : tb
